// ==== verification/core_take_model.sv ====
`timescale 1ns/10ps
// ==========
// core side: takes each presented exception, alternately at once and three cycles late
module core_take_model (
   input wire clk_i,
   input wire valid_i,
   output logic take_o
);
   integer lag = 0;
   initial begin
      take_o = 1'b0;
      forever begin
         @(posedge clk_i);
         #5;
         if (valid_i === 1'b1) begin
            repeat (lag) begin @(posedge clk_i); #5; end
            take_o = 1'b1;
            @(posedge clk_i);
            #5;
            take_o = 1'b0; // the old number still shows one cycle, so skip it
            lag = 3 - lag;
         end
      end
   end
endmodule // core_take_model

// ==== verification/exception_wake_router_monitor.sv ====
`timescale 1ns/10ps
`include "exc_router_defines.vh"
// ==========
// checker: exception ranks and wake gating seen at the top ports
module exception_wake_router_monitor #(
   parameter NUM = `NUM_VECTORS
) (
   input wire CLK_SYS_I,
   input wire RSTN_I,
   input wire CE_I,
   input wire [6*`PRIO_W-1:0] SYS_PRIO_I,
   input wire [NUM-1:0] IRQ_I,
   input wire [NUM-1:0] IRQ_EN_I,
   input wire [NUM*`PRIO_W-1:0] IRQ_PRIO_I,
   input wire IN_HANDLER_I,
   input wire [`PRIO_W-1:0] ACTIVE_PRIO_I,
   input wire EXC_VALID_O,
   input wire [7:0] EXC_NUM_O,
   input wire [4:0] EXC_RANK_O,
   input wire [1:0] POWER_MODE_O,
   input wire WAKE_O
);
   wire [NUM-1:0] hi;
   wire [NUM-1:0] ok;
   genvar g;
   // sources that may wake now; deep modes drop the timers and above
   generate
      for (g = 0; g < NUM; g = g + 1) begin : g_hi
         assign hi[g] = IRQ_PRIO_I[g*`PRIO_W +: `PRIO_W] > ACTIVE_PRIO_I;
      end
   endgenerate
   assign ok = IRQ_I & IRQ_EN_I & (POWER_MODE_O[1] ? `DEEP_WAKE_MASK : {NUM{1'b1}})
      & (IN_HANDLER_I ? hi : {NUM{1'b1}});
   // field index of a system exception in the shared priority bus
   function automatic integer slot(input [7:0] n);
      slot = (n < 8'h07) ? (n == 8'h06) : ((n < 8'h0D) ? n - 9 : n - 10);
   endfunction
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   property p_reset_rank; EXC_VALID_O && EXC_NUM_O == 8'h01 |-> EXC_RANK_O == 5'h0A; endproperty
   a_reset_rank: assert property (p_reset_rank) else $error("reset rank wrong");
   property p_no_nmi; EXC_VALID_O |-> EXC_NUM_O != 8'h02; endproperty
   a_no_nmi: assert property (p_no_nmi) else $error("nonmaskable shown");
   property p_hard_rank; EXC_VALID_O && EXC_NUM_O == 8'h03 |-> EXC_RANK_O == 5'h08; endproperty
   a_hard_rank: assert property (p_hard_rank) else $error("hard fault rank wrong");
   property p_legal_num;
      EXC_VALID_O |-> !(EXC_NUM_O inside {[8'h07:8'h0A], 8'h0D}); endproperty
   a_legal_num: assert property (p_legal_num) else $error("unused number shown");
   property p_sys_rank; EXC_VALID_O && EXC_NUM_O inside {[8'h04:8'h06], 8'h0B, 8'h0C, 8'h0E,
      8'h0F} |-> EXC_RANK_O == {2'h0, SYS_PRIO_I[3*slot(EXC_NUM_O) +: 3]}; endproperty
   a_sys_rank: assert property (p_sys_rank) else $error("system rank wrong");
   property p_core_wake; POWER_MODE_O == 2'h1 && CE_I && |ok |=> WAKE_O; endproperty
   a_core_wake: assert property (p_core_wake) else $error("core sleep not woken");
   property p_no_wake; POWER_MODE_O != 2'h0 && CE_I && ok == '0 |=> !WAKE_O; endproperty
   a_no_wake: assert property (p_no_wake) else $error("wake from barred source");
   property p_wake_active; WAKE_O && $past(POWER_MODE_O) != 2'h0 |-> POWER_MODE_O == 2'h0;
   endproperty
   a_wake_active: assert property (p_wake_active) else $error("no return to active");
   c_deep_wake: cover property (POWER_MODE_O[1] ##1 WAKE_O);
   c_hard: cover property (EXC_VALID_O && EXC_NUM_O == 8'h03);
   c_handler_wake: cover property (IN_HANDLER_I && WAKE_O);
endmodule // exception_wake_router_monitor

bind exception_wake_router exception_wake_router_monitor #(.NUM(NUM)) monitor_inst (
   .CLK_SYS_I, .RSTN_I, .CE_I, .SYS_PRIO_I, .IRQ_I, .IRQ_EN_I, .IRQ_PRIO_I, .IN_HANDLER_I,
   .ACTIVE_PRIO_I, .EXC_VALID_O, .EXC_NUM_O, .EXC_RANK_O, .POWER_MODE_O, .WAKE_O);

// ==== verification/exception_wake_router_tb.sv ====
`timescale 1ns/10ps
module exception_wake_router_tb;
   logic clk = 1'b0, rstn = 1'b0, reset_ev = 1'b0, sleep_req = 1'b0, in_h = 1'b0;
   logic [6:0] cause = 7'h00;
   logic [2:0] hen = 3'h7, act_p = 3'h0;
   logic [17:0] sprio = 18'h0_0000;
   logic [18:0] irq = 19'h0_0000, irq_en = 19'h7_FFFF; // enabled before any request
   logic [56:0] iprio = 57'h0;
   logic [1:0] sleep_mode = 2'h0;
   logic [63:0] r;
   logic [7:0] expq[$];
   wire take, valid, wake;
   wire [7:0] num;
   wire [1:0] mode;
   wire [18:0] pend;
   integer err_count = 0, compares = 0, seed = 32'h91a1_1cf4, i, k, v, w;
   integer vs[4] = '{0, 11, 12, 18};
   always #50 clk = ~clk;
   exception_wake_router #(.NUM(19)) exception_wake_router_inst (.CLK_SYS_I(clk),
      .RSTN_I(rstn), .CE_I(1'b1), .RESET_EVENT_I(reset_ev), .MEM_FAULT_I(cause[0]),
      .BUS_FAULT_I(cause[1]), .USAGE_FAULT_I(cause[2]), .HANDLER_EN_I(hen),
      .SUPERVISOR_CALL_I(cause[3]), .DEBUG_EVENT_I(cause[4]), .PENDED_SERVICE_SET_I(cause[5]),
      .SYSTEM_TICK_EXPIRE_I(cause[6]), .SYS_PRIO_I(sprio), .IRQ_I(irq), .IRQ_EN_I(irq_en),
      .IRQ_PRIO_I(iprio), .SLEEP_REQ_I(sleep_req), .SLEEP_MODE_I(sleep_mode),
      .IN_HANDLER_I(in_h), .ACTIVE_PRIO_I(act_p), .TAKE_I(take), .EXC_VALID_O(valid),
      .EXC_NUM_O(num), .EXC_RANK_O(), .POWER_MODE_O(mode), .WAKE_O(wake), .PENDING_O(pend));
   core_take_model core_take_model_inst (.clk_i(clk), .valid_i(valid), .take_o(take));
   task cyc; @(posedge clk); #5; endtask
   task note(input [7:0] n); expq.push_back(n); endtask
   task tally(input logic bad, input [31:0] want, input [31:0] got);
      compares = compares + 1;
      if (bad) begin
         err_count = err_count + 1;
         $display("wrong value at %0t: expected %h got %h", $time, want, got);
      end
   endtask
   task chk_exc(input [7:0] want, input [7:0] got); tally(want !== got, want, got); endtask
   task chk_mode(input [1:0] want, input [1:0] got);
      tally(want !== got, {6'h0, want}, {6'h0, got});
   endtask
   task chk_pend(input [18:0] want, input [18:0] got);
      tally(want !== got, {13'h0, want}, {13'h0, got});
   endtask
   task chk_wake(input logic want, input logic got);
      tally(want !== got, {31'h0, want}, {31'h0, got});
   endtask
   // wait for the core to take everything noted; any leftovers count as a single miss
   task drain;
      integer t;
      for (t = 0; t < 300 && expq.size() != 0; t++) cyc;
      if (expq.size() != 0) begin chk_exc(expq[0], 8'hFF); expq.delete(); end
      repeat (3) cyc;
   endtask
   // enter mode m, pulse vector x, then force a wake from vector 0 if x was barred
   task sleep_try(input [1:0] m, input integer x, input logic inh);
      logic woke;
      woke = (m == 2'h1 || x < 12) && (!inh || iprio[x*3 +: 3] > act_p);
      in_h = inh;
      sleep_mode = m;
      sleep_req = 1'b1;
      cyc;
      sleep_req = 1'b0;
      chk_mode(m, mode);
      irq[x] = 1'b1;
      note(8'h10 + x[7:0]);
      cyc;
      irq[x] = 1'b0;
      chk_mode(woke ? 2'h0 : m, mode);
      chk_wake(woke, wake);
      drain;
      in_h = 1'b0;
      if (!woke) begin
         irq[0] = 1'b1;
         note(8'h10);
         cyc;
         irq[0] = 1'b0;
         chk_mode(2'h0, mode);
         chk_wake(1'b1, wake);
         drain;
      end
   endtask
   // every taken exception must be the oldest one noted by the driver; looked at
   // mid-cycle, where the take strobe and the number on show have both settled
   always @(negedge clk) begin
      if (take === 1'b1 && valid === 1'b1) begin
         if (expq.size() == 0) chk_exc(8'hFF, num);
         else chk_exc(expq.pop_front(), num);
      end
   end
   task give_verdict;
      if (err_count == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // the tests need well under 1000 cycles; this cuts a hang at 10000
   initial begin
      #1_000_000;
      err_count = err_count + 1;
      give_verdict;
   end
   initial begin
      r = {$random(seed), $random(seed)};
      iprio = r[56:0];
      sprio = r[63:46];
      note(8'h01);
      repeat (16) cyc;
      rstn = 1'b1;
      drain;
      // three handled faults, the same three escalated, then the other system causes
      for (k = 0; k < 10; k++) begin
         hen = (k < 3) ? 3'h7 : 3'h0;
         cause[(k < 6) ? k % 3 : k - 3] = 1'b1;
         note(k < 3 ? 8'h04 + k : (k < 6 ? 8'h03 : (k < 8 ? 8'h05 + k : 8'h06 + k)));
         cyc;
         cause = 7'h00;
         drain;
      end
      hen = 3'h7;
      reset_ev = 1'b1;
      cause[0] = 1'b1;
      note(8'h01);
      note(8'h04);
      cyc;
      reset_ev = 1'b0;
      cause = 7'h00;
      drain;
      // random pairs raised together leave in priority order, ties to the lower vector
      for (k = 0; k < 6; k++) begin
         v = $unsigned($random(seed)) % 19;
         w = ($unsigned($random(seed)) % 18 + v + 1) % 19;
         irq[v] = 1'b1;
         irq[w] = 1'b1;
         if (iprio[v*3 +: 3] > iprio[w*3 +: 3] || (iprio[v*3 +: 3] == iprio[w*3 +: 3] && v < w))
            begin note(8'h10 + v[7:0]); note(8'h10 + w[7:0]); end
         else begin note(8'h10 + w[7:0]); note(8'h10 + v[7:0]); end
         cyc;
         chk_pend((19'h0_0001 << v) | (19'h0_0001 << w), pend);
         irq = 19'h0_0000;
         drain;
      end
      irq_en[5] = 1'b0;
      irq[5] = 1'b1;
      cyc;
      irq[5] = 1'b0;
      chk_pend(19'h0_0000, pend);
      repeat (6) cyc;
      irq_en[5] = 1'b1;
      for (k = 1; k < 4; k++) foreach (vs[i]) sleep_try(k[1:0], vs[i], 1'b0);
      for (k = 0; k < 4; k++) begin
         r = $random(seed);
         act_p = r[2:0];
         sleep_try(2'h1, $unsigned($random(seed)) % 19, 1'b1);
      end
      give_verdict;
   end
endmodule // exception_wake_router_tb

// ==== verilog/exc_router_defines.vh ====
`ifndef EXC_ROUTER_DEFINES_VH
`define EXC_ROUTER_DEFINES_VH
// exception numbers
`define EXC_NONE 4'h0
`define EXC_RESET 4'h1
`define EXC_NMI 4'h2
`define EXC_HARD_FAULT 4'h3
`define EXC_MEM_MANAGE 4'h4
`define EXC_BUS_FAULT 4'h5
`define EXC_USAGE_FAULT 4'h6
`define EXC_SUPERVISOR_CALL 4'hB
`define EXC_DEBUG_MON 4'hC
`define EXC_PENDED_SERVICE 4'hE
`define EXC_SYSTEM_TICK 4'hF
// peripheral vectors
`define NUM_VECTORS 19
`define DEEP_WAKE_MASK 19'h0_0FFF
`define VEC_OFFSET 8'h10
// priority fields: 3-bit levels; larger value is more urgent in this block
`define PRIO_W 3
// fixed urgency ranks (above any programmable level)
`define RANK_RESET 5'h0A
`define RANK_NMI 5'h09
`define RANK_HARD 5'h08
// power modes
`define MODE_ACTIVE 2'h0
`define MODE_CORE_SLEEP 2'h1
`define MODE_SYS_SLEEP 2'h2
`define MODE_HIBERNATE 2'h3
`endif

// ==== verilog/exception_wake_router.v ====
`timescale 1ns/10ps
`include "exc_router_defines.vh"
module exception_wake_router #(
   parameter NUM = `NUM_VECTORS
) (
   input wire CLK_SYS_I,
   input wire RSTN_I,
   input wire CE_I,
   input wire RESET_EVENT_I,
   input wire MEM_FAULT_I,
   input wire BUS_FAULT_I,
   input wire USAGE_FAULT_I,
   input wire [2:0] HANDLER_EN_I,
   input wire SUPERVISOR_CALL_I,
   input wire DEBUG_EVENT_I,
   input wire PENDED_SERVICE_SET_I,
   input wire SYSTEM_TICK_EXPIRE_I,
   input wire [6*`PRIO_W-1:0] SYS_PRIO_I,
   input wire [NUM-1:0] IRQ_I,
   input wire [NUM-1:0] IRQ_EN_I,
   input wire [NUM*`PRIO_W-1:0] IRQ_PRIO_I,
   input wire SLEEP_REQ_I,
   input wire [1:0] SLEEP_MODE_I,
   input wire IN_HANDLER_I,
   input wire [`PRIO_W-1:0] ACTIVE_PRIO_I,
   input wire TAKE_I,
   output reg EXC_VALID_O,
   output reg [7:0] EXC_NUM_O,
   output reg [4:0] EXC_RANK_O,
   output reg [1:0] POWER_MODE_O,
   output reg WAKE_O,
   output reg [NUM-1:0] PENDING_O
);
   // ==========================================================
   // reset release
   reg rst_meta;
   reg rst_sync;
   wire rst_n;
   always @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end
   assign rst_n = rst_sync;

   // ==========================================================
   // fault routing
   wire mem_req;
   wire bus_req;
   wire usage_req;
   wire hard_req;
   fault_escalate u_fault (
      .mem_fault_i(MEM_FAULT_I),
      .bus_fault_i(BUS_FAULT_I),
      .usage_fault_i(USAGE_FAULT_I),
      .handler_en_i(HANDLER_EN_I),
      .mem_req_o(mem_req),
      .bus_req_o(bus_req),
      .usage_req_o(usage_req),
      .hard_req_o(hard_req)
   );

   // ==========================================================
   // wake decision
   wire [NUM-1:0] wake_vec;
   wake_filter #(.NUM(NUM)) u_wake (
      .irq_i(IRQ_I & IRQ_EN_I),
      .prio_i(IRQ_PRIO_I),
      .mode_i(POWER_MODE_O),
      .in_handler_i(IN_HANDLER_I),
      .active_prio_i(ACTIVE_PRIO_I),
      .wake_o(wake_vec)
   );

   // ==========================================================
   // pending system exceptions, one bit per programmable slot
   // slot order: mem, bus, usage, supervisor call, debug, pended service, system tick
   reg [6:0] sys_pend;
   reg hard_pend;
   reg reset_pend;
   wire [6:0] sys_set;
   wire [6:0] sys_clr;
   wire hard_clr;
   wire reset_clr;
   assign sys_set = {SYSTEM_TICK_EXPIRE_I, PENDED_SERVICE_SET_I, DEBUG_EVENT_I, SUPERVISOR_CALL_I,
      usage_req, bus_req, mem_req};

   // programmable priority of a system slot (mem shares slot 0 with bus's field layout)
   function [`PRIO_W-1:0] sys_prio;
      input [2:0] slot;
      input [6*`PRIO_W-1:0] all;
      reg [2:0] idx;
      begin
         idx = (slot == 3'h0) ? 3'h0 : slot - 3'h1;
         sys_prio = all[idx*`PRIO_W +: `PRIO_W];
      end
   endfunction

   // exception number for each programmable slot
   // the slot is an integer so loop and generate indices pass in without truncation
   function [3:0] sys_num;
      input integer slot;
      begin
         case (slot)
            0: sys_num = `EXC_MEM_MANAGE;
            1: sys_num = `EXC_BUS_FAULT;
            2: sys_num = `EXC_USAGE_FAULT;
            3: sys_num = `EXC_SUPERVISOR_CALL;
            4: sys_num = `EXC_DEBUG_MON;
            5: sys_num = `EXC_PENDED_SERVICE;
            default: sys_num = `EXC_SYSTEM_TICK;
         endcase
      end
   endfunction

   // the core takes whatever is on show in the cycle in which it raises its take strobe
   wire take_now;
   assign take_now = TAKE_I & EXC_VALID_O;

   // true when the number on show is a given system exception; all inputs are
   // arguments so that continuous assignments using it follow every change
   function shows_num;
      input [7:0] shown;
      input [3:0] code;
      begin
         shows_num = (shown == {4'h0, code});
      end
   endfunction

   // ==========================================================
   // arbitration: fixed ranks first, then highest programmable value
   reg [7:0] next_num;
   reg [4:0] next_rank;
   reg next_valid;
   reg [4:0] best;
   reg [4:0] cand;
   reg [7:0] sel;
   integer i;
   always @* begin
      next_valid = 1'b0;
      next_num = 8'h00;
      next_rank = 5'h00;
      best = 5'h00;
      cand = 5'h00;
      sel = 8'h00;
      if (reset_pend) begin
         next_valid = 1'b1;
         next_num = {4'h0, `EXC_RESET};
         next_rank = `RANK_RESET;
      end else if (hard_pend) begin
         next_valid = 1'b1;
         next_num = {4'h0, `EXC_HARD_FAULT};
         next_rank = `RANK_HARD;
      end else begin
         // lower number wins a tie, so scan downward with >=
         for (i = NUM - 1; i >= 0; i = i - 1) begin
            cand = {2'h0, IRQ_PRIO_I[i*`PRIO_W +: `PRIO_W]};
            if (PENDING_O[i] && (!next_valid || cand >= best)) begin
               next_valid = 1'b1;
               best = cand;
               sel = `VEC_OFFSET + i[7:0];
            end
         end
         for (i = 6; i >= 0; i = i - 1) begin
            cand = {2'h0, sys_prio(i[2:0], SYS_PRIO_I)};
            if (sys_pend[i] && (!next_valid || cand >= best)) begin
               next_valid = 1'b1;
               best = cand;
               sel = {4'h0, sys_num(i)};
            end
         end
         next_num = sel;
         next_rank = best;
      end
   end

   // the nonmaskable exception has no source here, so nothing ever selects it
   // its rank constant is kept only to document where it would sit
   assign reset_clr = take_now && shows_num(EXC_NUM_O, `EXC_RESET);
   assign hard_clr = take_now && shows_num(EXC_NUM_O, `EXC_HARD_FAULT);
   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : gen_clr
         assign sys_clr[g] = take_now && shows_num(EXC_NUM_O, sys_num(g));
      end
   endgenerate

   // ==========================================================
   // pending state: a new request wins over a take in the same cycle
   integer k;
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         reset_pend <= 1'b1; // coming out of any reset is itself exception 1
         hard_pend <= 1'b0;
         sys_pend <= 7'h00;
         PENDING_O <= {NUM{1'b0}};
      end else if (CE_I) begin
         reset_pend <= RESET_EVENT_I | (reset_pend & ~reset_clr);
         hard_pend <= hard_req | (hard_pend & ~hard_clr);
         sys_pend <= sys_set | (sys_pend & ~sys_clr);
         for (k = 0; k < NUM; k = k + 1) begin
            PENDING_O[k] <= (IRQ_I[k] & IRQ_EN_I[k]) | (PENDING_O[k] & ~(take_now &&
               EXC_NUM_O == `VEC_OFFSET + k[7:0]));
         end
      end
   end

   // ==========================================================
   // exception presentation to the core
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         EXC_VALID_O <= 1'b0;
         EXC_NUM_O <= 8'h00;
         EXC_RANK_O <= 5'h00;
      end else if (CE_I) begin
         EXC_VALID_O <= next_valid;
         EXC_NUM_O <= next_num;
         EXC_RANK_O <= next_rank;
      end
   end

   // ==========================================================
   // power mode tracking, kept one-hot so each mode is a single flip-flop
   localparam [3:0] ST_ACTIVE = 4'b0001;
   localparam [3:0] ST_CORE = 4'b0010;
   localparam [3:0] ST_SYS = 4'b0100;
   localparam [3:0] ST_HIB = 4'b1000;
   reg [3:0] pwr_state;
   reg [3:0] next_state;
   wire any_wake;
   assign any_wake = |wake_vec;

   // one-hot target for a requested mode code; the active code asks for nothing
   function [3:0] mode_state;
      input [1:0] code;
      begin
         case (code)
            `MODE_CORE_SLEEP: mode_state = ST_CORE;
            `MODE_SYS_SLEEP: mode_state = ST_SYS;
            `MODE_HIBERNATE: mode_state = ST_HIB;
            default: mode_state = ST_ACTIVE;
         endcase
      end
   endfunction

   // mode code shown to the rest of the system for each one-hot state
   function [1:0] state_code;
      input [3:0] st;
      begin
         case (st)
            ST_CORE: state_code = `MODE_CORE_SLEEP;
            ST_SYS: state_code = `MODE_SYS_SLEEP;
            ST_HIB: state_code = `MODE_HIBERNATE;
            default: state_code = `MODE_ACTIVE;
         endcase
      end
   endfunction

   // sleep is only entered from active mode; a request made inside a handler is still
   // honoured, since keeping out of sleep there is left to software
   always @* begin
      next_state = pwr_state;
      case (pwr_state)
         ST_ACTIVE: begin
            if (SLEEP_REQ_I) begin
               next_state = mode_state(SLEEP_MODE_I);
            end
         end
         ST_CORE: begin
            if (any_wake) begin
               next_state = ST_ACTIVE;
            end
         end
         ST_SYS, ST_HIB: begin
            if (any_wake) begin
               next_state = ST_ACTIVE;
            end
         end
         default: begin
            next_state = ST_ACTIVE; // a corrupted state falls back to running
         end
      endcase
   end

   // the mode code is registered beside the state so the output comes from a flop
   always @(posedge CLK_SYS_I or negedge rst_n) begin
      if (!rst_n) begin
         pwr_state <= ST_ACTIVE;
         POWER_MODE_O <= `MODE_ACTIVE;
         WAKE_O <= 1'b0;
      end else if (CE_I) begin
         pwr_state <= next_state;
         POWER_MODE_O <= state_code(next_state);
         WAKE_O <= any_wake;
      end
   end
endmodule // exception_wake_router

// ==== verilog/fault_escalate.v ====
`timescale 1ns/10ps
`include "exc_router_defines.vh"
// maps fault causes onto system exceptions, escalating disabled ones
module fault_escalate (
   input wire mem_fault_i,
   input wire bus_fault_i,
   input wire usage_fault_i,
   input wire [2:0] handler_en_i,
   output wire mem_req_o,
   output wire bus_req_o,
   output wire usage_req_o,
   output wire hard_req_o
);
   // a fault with its own handler enabled goes there, otherwise it becomes hard fault
   assign mem_req_o = mem_fault_i & handler_en_i[0];
   assign bus_req_o = bus_fault_i & handler_en_i[1];
   assign usage_req_o = usage_fault_i & handler_en_i[2];
   assign hard_req_o = (mem_fault_i & ~handler_en_i[0]) | (bus_fault_i & ~handler_en_i[1])
      | (usage_fault_i & ~handler_en_i[2]);
endmodule // fault_escalate

// ==== verilog/wake_filter.v ====
`timescale 1ns/10ps
`include "exc_router_defines.vh"
// decides which peripheral vectors may wake the core in the present mode
module wake_filter #(
   parameter NUM = `NUM_VECTORS
) (
   input wire [NUM-1:0] irq_i,
   input wire [NUM*`PRIO_W-1:0] prio_i,
   input wire [1:0] mode_i,
   input wire in_handler_i,
   input wire [`PRIO_W-1:0] active_prio_i,
   output wire [NUM-1:0] wake_o
);
   localparam [NUM-1:0] DEEP = `DEEP_WAKE_MASK;
   genvar g;
   generate
      for (g = 0; g < NUM; g = g + 1) begin : gen_wake
         wire deep_ok;
         wire prio_ok;
         // deeper modes only accept the always-on sources
         assign deep_ok = (mode_i == `MODE_CORE_SLEEP) | DEEP[g];
         // inside a handler only a strictly more urgent source may wake
         assign prio_ok = ~in_handler_i |
            (prio_i[g*`PRIO_W +: `PRIO_W] > active_prio_i);
         assign wake_o[g] = irq_i[g] & deep_ok & prio_ok & (mode_i != `MODE_ACTIVE);
      end
   endgenerate
endmodule // wake_filter
